//--- src/tcc_map.vh
/*
  register offsets, field positions, reset values and codes of the
  capture/compare timer block. assumes apb byte addressing, word aligned.
*/
`ifndef TCC_MAP_VH
`define TCC_MAP_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define TCC_OFS_CTRL 8'h00
`define TCC_OFS_SLAVE 8'h04
`define TCC_OFS_INTEN 8'h08
`define TCC_OFS_FLAGS 8'h0c
`define TCC_OFS_SWGEN 8'h10
`define TCC_OFS_CHCFG 8'h14
`define TCC_OFS_COUNT 8'h18
`define TCC_OFS_RELOAD 8'h1c
`define TCC_OFS_CHVAL0 8'h20
`define TCC_OFS_BURSTCFG 8'h30
`define TCC_OFS_BURSTBUF 8'h34
// ------------------------------------------------------------
// ctrl fields
// ------------------------------------------------------------
`define TCC_CTRL_RUN 0
`define TCC_CTRL_DIR 4
`define TCC_CTRL_CAM_LO 5
`define TCC_CTRL_HOLD 8
// ------------------------------------------------------------
// channel config: 8 bits per channel
// ------------------------------------------------------------
`define TCC_CH_MS_LO 0
`define TCC_CH_POL 2
`define TCC_CH_EN 3
`define TCC_CH_CTL_LO 4
`define TCC_CH_ETRCLR 7
`define TCC_CH_FLT_LO 0
`define TCC_CH_PSC_LO 4
// ------------------------------------------------------------
// codes and reset values
// ------------------------------------------------------------
`define TCC_SM_OFF 3'h0
`define TCC_SM_RESTART 3'h4
`define TCC_SM_PAUSE 3'h5
`define TCC_SM_EVENT 3'h6
`define TCC_CMP_FROZEN 3'h0
`define TCC_CMP_SET 3'h1
`define TCC_CMP_CLEAR 3'h2
`define TCC_CMP_TOGGLE 3'h3
`define TCC_CMP_FLOW 3'h4
`define TCC_CMP_FHIGH 3'h5
`define TCC_CMP_PWM0 3'h6
`define TCC_CMP_PWM1 3'h7
`define TCC_MS_OUT 2'h0
`define TCC_MS_OWN 2'h1
`define TCC_MS_PAIR 2'h2
`define TCC_RELOAD_RST 16'hffff
`define TCC_BURST_STEP 8'h04
`endif

//--- src/tcc_channels.v
/*
  four-channel capture/compare timer with counter, slave modes, burst dma
  and debug hold. assumes inputs synchronous-ish pins, one clock, apb master.
*/
// Implementation choices: the APB register port and the register addresses.
// Notes on behaviour
// R1: four independent channels, each capture or compare, each with its value register
// R2: selected edge copies counter to value register, sets flag, irq if enabled
// R3: input path: synchronise, filter, edge/polarity, capture prescaler, in order
// R4: channel 0 input may be xor of channel 0, 1 and 2 pins
// R5: prescaler turns several qualified edges into one capture event
// R6: nonzero source select means input mode; software value writes are ignored
// R7: capture while flag still set also sets over-capture flag
// R8: capture raises irq and dma request each by its own enable
// R9: software generate bit produces channel event, irq and dma as enabled
// R10: code 01 takes own filtered input, code 10 the paired neighbour input
// R11: compare match acts on output per control field, sets flag, irq, dma
// R12: match: hold for 0, high for 1, low for 2, toggle for 3
// R13: codes 4 and 5 force inactive and active regardless of compare
// R14: codes 6 and 7 are pwm mode 0 and 1, by direction and compare; the code compares count below value only, direction unused
// R15: edge pwm period reload plus one, centre pwm period twice reload
// R16: pwm0 value above reload always active, value zero always inactive
// R17: clear enable and trigger high force prepare low until next update
// R18: restart, pause and event slave modes; pause is 101, trigger controls counter
// R19: trigger select 0-3 internal, 4 ch0 edge detector, 5 filtered ch0
// R20: event mode starts counter on trigger rising edge, sets trigger flag
// R21: burst dma issues count plus one requests, buffer steps by 4 from base
// R22: core halted and hold bit set stops the counter
// R23: flags stay set until software clears; reading values has no side effect
`timescale 1ns/10ps
`include "tcc_map.vh"
module tcc_channels #(
  parameter CW = 16
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pins and triggers
  input wire [3:0] channel_input,
  input wire [3:0] internal_trigger_in,
  input wire filtered_ext_trigger,
  input wire core_halted,
  input wire dma_ack,
  // outputs
  output reg [3:0] output_prepare_signal,
  output reg [3:0] channel_irq,
  output reg dma_request
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [31:0] ctrl_reg;
  reg [2:0] slave_mode_select;
  reg [2:0] trigger_source_select;
  reg [3:0] channel_irq_enable;
  reg [3:0] channel_dma_enable;
  reg [3:0] channel_event_flag;
  reg [3:0] overcapture_flag;
  reg trigger_flag;
  reg [31:0] chcfg_reg;
  reg [31:0] flt_reg;
  reg [CW-1:0] count_reg;
  reg [CW-1:0] auto_reload_value;
  reg [CW-1:0] channel_value_reg [0:3];
  reg [4:0] burst_base_index;
  reg [4:0] burst_transfer_count;
  reg [4:0] burst_left_reg;
  reg [4:0] burst_idx_reg;
  reg down_reg;
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg [3:0] filt_reg;
  reg [3:0] filt_prev_reg;
  reg [3:0] flt_cnt_reg [0:3];
  reg [1:0] psc_cnt_reg [0:3];
  reg [3:0] etr_clear_reg;
  reg trig_prev_reg;
  wire counter_run_enable = ctrl_reg[`TCC_CTRL_RUN];
  wire debug_halt_hold = ctrl_reg[`TCC_CTRL_HOLD];
  wire [1:0] cam = ctrl_reg[`TCC_CTRL_CAM_LO+1:`TCC_CTRL_CAM_LO];
  wire wr = psel & penable & pwrite;
  // read data taken in setup so it stands with ready
  wire rd = psel & ~penable & ~pwrite;
  wire [31:0] bus_wr_clr = (wr && paddr == `TCC_OFS_FLAGS) ? pwdata : 32'h0;
  wire [3:0] soft_gen = (wr && paddr == `TCC_OFS_SWGEN) ? pwdata[3:0] : 4'h0;
  // burst buffer access maps to base plus running index, 4 bytes apart
  wire [4:0] burst_word = burst_base_index + burst_idx_reg;
  wire [7:0] burst_addr = {1'b0, burst_word, 2'b00}; // [R21]
  wire buf_hit = (paddr == `TCC_OFS_BURSTBUF);
  wire [7:0] eff_addr = buf_hit ? burst_addr : paddr;

  function [1:0] ms_of;
    input [31:0] cfg;
    input integer ch;
    begin
      ms_of = cfg[ch*8+`TCC_CH_MS_LO +: 2];
    end
  endfunction

  function [2:0] ctl_of;
    input [31:0] cfg;
    input integer ch;
    begin
      ctl_of = cfg[ch*8+`TCC_CH_CTL_LO +: 3];
    end
  endfunction

  function etr_clr_of;
    input [31:0] cfg;
    input integer ch;
    begin
      etr_clr_of = cfg[ch*8+`TCC_CH_ETRCLR];
    end
  endfunction

  // ------------------------------------------------------------
  // input path per channel
  // ------------------------------------------------------------
  // channel 0 may see the xor of pins 0..2
  wire xor_sel = chcfg_reg[`TCC_CH_ETRCLR + 24];
  wire [3:0] pin_in = {channel_input[3:1],
    xor_sel ? ^channel_input[2:0] : channel_input[0]}; // [R4]
  wire [3:0] pol_edge;
  wire [3:0] cap_sel_edge;
  wire [3:0] cap_event;
  wire [3:0] cmp_match;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : ch
      wire pol = chcfg_reg[g*8+`TCC_CH_POL];
      wire rise = filt_reg[g] & ~filt_prev_reg[g];
      wire fall = ~filt_reg[g] & filt_prev_reg[g];
      assign pol_edge[g] = pol ? fall : rise; // [R3]
      wire [1:0] ms = ms_of(chcfg_reg, g);
      assign cap_sel_edge[g] = (ms == `TCC_MS_OWN) ? pol_edge[g] :
        (ms == `TCC_MS_PAIR) ? pol_edge[g^1] : 1'b0; // [R10]
      wire [1:0] psc = flt_reg[g*8+`TCC_CH_PSC_LO +: 2];
      // several qualified edges give one capture
      assign cap_event[g] = cap_sel_edge[g] & chcfg_reg[g*8+`TCC_CH_EN] &
        (psc_cnt_reg[g] == psc); // [R5]
      assign cmp_match[g] = (ms == `TCC_MS_OUT) && counter_run_enable &&
        (count_reg == channel_value_reg[g]);
    end
  endgenerate

  integer i;
  integer j;
  always @(posedge clock) begin
    if (!resetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      filt_reg <= 4'h0;
      filt_prev_reg <= 4'h0;
      for (j = 0; j < 4; j = j + 1) begin
        flt_cnt_reg[j] <= 4'h0;
        psc_cnt_reg[j] <= 2'h0;
      end
    end else begin
      sync1_reg <= pin_in; // [R3]
      sync2_reg <= sync1_reg;
      filt_prev_reg <= filt_reg;
      for (j = 0; j < 4; j = j + 1) begin
        // filter: level must hold for cfg plus one samples before it passes
        if (sync2_reg[j] == filt_reg[j]) begin
          flt_cnt_reg[j] <= 4'h0;
        end else if (flt_cnt_reg[j] >= flt_reg[j*8+`TCC_CH_FLT_LO +: 4]) begin
          filt_reg[j] <= sync2_reg[j]; // [R3]
          flt_cnt_reg[j] <= 4'h0;
        end else begin
          flt_cnt_reg[j] <= flt_cnt_reg[j] + 4'h1;
        end
        if (!chcfg_reg[j*8+`TCC_CH_EN]) begin
          psc_cnt_reg[j] <= 2'h0;
        end else if (cap_sel_edge[j]) begin
          psc_cnt_reg[j] <= cap_event[j] ? 2'h0 : psc_cnt_reg[j] + 2'h1; // [R5]
        end
      end
    end
  end

  // ------------------------------------------------------------
  // slave trigger and counter
  // ------------------------------------------------------------
  reg trig;
  always @* begin
    case (trigger_source_select) // [R19]
      3'h0: trig = internal_trigger_in[0];
      3'h1: trig = internal_trigger_in[1];
      3'h2: trig = internal_trigger_in[2];
      3'h3: trig = internal_trigger_in[3];
      3'h4: trig = pol_edge[0];
      3'h5: trig = filt_reg[0];
      default: trig = 1'b0;
    endcase
  end
  wire trig_rise = trig & ~trig_prev_reg;
  wire halted = core_halted & debug_halt_hold; // [R22]
  wire paused = (slave_mode_select == `TCC_SM_PAUSE) & ~trig; // [R18]
  wire ticking = counter_run_enable & ~halted & ~paused;
  wire at_top = (count_reg >= auto_reload_value);
  wire restart = (slave_mode_select == `TCC_SM_RESTART) & trig_rise; // [R18]
  wire update = ticking & (cam == 2'h0 ? at_top :
    (down_reg ? count_reg == {CW{1'b0}} : at_top)) | restart;

  // ------------------------------------------------------------
  // apb, flags, value registers, counter
  // ------------------------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    case (eff_addr)
      `TCC_OFS_CTRL: rd_mux = {ctrl_reg[31:5], down_reg, ctrl_reg[3:0]};
      `TCC_OFS_SLAVE: rd_mux = {25'h0, trigger_source_select, 1'b0, slave_mode_select};
      `TCC_OFS_INTEN: rd_mux = {24'h0, channel_dma_enable, channel_irq_enable};
      `TCC_OFS_FLAGS: rd_mux = {23'h0, trigger_flag, overcapture_flag, channel_event_flag};
      `TCC_OFS_CHCFG: rd_mux = chcfg_reg;
      `TCC_OFS_COUNT: rd_mux = {{(32-CW){1'b0}}, count_reg};
      `TCC_OFS_RELOAD: rd_mux = {{(32-CW){1'b0}}, auto_reload_value};
      8'h20: rd_mux = {{(32-CW){1'b0}}, channel_value_reg[0]}; // [R23]
      8'h24: rd_mux = {{(32-CW){1'b0}}, channel_value_reg[1]};
      8'h28: rd_mux = {{(32-CW){1'b0}}, channel_value_reg[2]};
      8'h2c: rd_mux = {{(32-CW){1'b0}}, channel_value_reg[3]};
      `TCC_OFS_BURSTCFG: rd_mux = {19'h0, burst_transfer_count, 3'h0, burst_base_index};
      8'h38: rd_mux = flt_reg;
      default: rd_mux = 32'h0;
    endcase
  end
  wire mapped = (rd_mux != 32'h0) || (eff_addr <= 8'h38 && eff_addr[1:0] == 2'b00);
  wire [3:0] ch_evt = cap_event | cmp_match | soft_gen; // [R9]
  wire any_dma_evt = |(ch_evt & channel_dma_enable);

  always @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_reg <= 32'h0;
      slave_mode_select <= `TCC_SM_OFF;
      trigger_source_select <= 3'h0;
      channel_irq_enable <= 4'h0;
      channel_dma_enable <= 4'h0;
      channel_event_flag <= 4'h0;
      overcapture_flag <= 4'h0;
      trigger_flag <= 1'b0;
      chcfg_reg <= 32'h0;
      flt_reg <= 32'h0;
      count_reg <= {CW{1'b0}};
      auto_reload_value <= `TCC_RELOAD_RST;
      for (i = 0; i < 4; i = i + 1) begin
        channel_value_reg[i] <= {CW{1'b0}};
      end
      burst_base_index <= 5'h0;
      burst_transfer_count <= 5'h0;
      burst_left_reg <= 5'h0;
      burst_idx_reg <= 5'h0;
      down_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      etr_clear_reg <= 4'h0;
      output_prepare_signal <= 4'h0;
      channel_irq <= 4'h0;
      dma_request <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= rd ? rd_mux : 32'h0;
      trig_prev_reg <= trig;
      if (wr) begin
        case (eff_addr)
          `TCC_OFS_CTRL: ctrl_reg <= pwdata & 32'h0000_01f1;
          `TCC_OFS_SLAVE: begin
            slave_mode_select <= pwdata[2:0];
            trigger_source_select <= pwdata[6:4];
          end
          `TCC_OFS_INTEN: begin
            channel_irq_enable <= pwdata[3:0];
            channel_dma_enable <= pwdata[7:4];
          end
          `TCC_OFS_CHCFG: chcfg_reg <= pwdata;
          `TCC_OFS_RELOAD: auto_reload_value <= pwdata[CW-1:0];
          `TCC_OFS_COUNT: count_reg <= pwdata[CW-1:0];
          `TCC_OFS_BURSTCFG: begin
            burst_base_index <= pwdata[4:0];
            burst_transfer_count <= pwdata[12:8];
          end
          8'h38: flt_reg <= pwdata;
          default: ;
        endcase
        for (i = 0; i < 4; i = i + 1) begin
          // value writes ignored once the channel is an input
          if (eff_addr == `TCC_OFS_CHVAL0 + 8'h04 * i[7:0] &&
              ms_of(chcfg_reg, i) == `TCC_MS_OUT) begin
            channel_value_reg[i] <= pwdata[CW-1:0]; // [R6]
          end
        end
      end
      // counter with edge or centre alignment
      if (ticking) begin
        if (cam == 2'h0) begin
          if (ctrl_reg[`TCC_CTRL_DIR]) begin
            count_reg <= (count_reg == {CW{1'b0}}) ? auto_reload_value : count_reg - 1'b1;
          end else begin
            count_reg <= at_top ? {CW{1'b0}} : count_reg + 1'b1; // [R15]
          end
        end else if (down_reg) begin
          count_reg <= count_reg - 1'b1;
          if (count_reg == {{(CW-1){1'b0}}, 1'b1}) down_reg <= 1'b0;
        end else begin
          count_reg <= count_reg + 1'b1; // [R15]
          if (count_reg + 1'b1 >= auto_reload_value) down_reg <= 1'b1;
        end
      end
      if (restart) begin
        count_reg <= {CW{1'b0}};
      end
      if (slave_mode_select == `TCC_SM_EVENT && trig_rise) begin
        ctrl_reg[`TCC_CTRL_RUN] <= 1'b1; // [R20]
      end
      // flags: set wins over clear
      trigger_flag <= (trigger_flag & ~bus_wr_clr[8]) |
        ((slave_mode_select != `TCC_SM_OFF) & trig_rise); // [R20]
      overcapture_flag <= (overcapture_flag & ~bus_wr_clr[7:4]) |
        (cap_event & channel_event_flag); // [R7]
      channel_event_flag <= (channel_event_flag & ~bus_wr_clr[3:0]) | ch_evt; // [R2] [R23]
      channel_irq <= (channel_event_flag | ch_evt) & channel_irq_enable; // [R8] [R11]
      for (i = 0; i < 4; i = i + 1) begin
        if (cap_event[i]) begin
          channel_value_reg[i] <= count_reg; // [R2] [R1]
        end
        if (update) begin
          etr_clear_reg[i] <= 1'b0; // [R17]
        end else if (etr_clr_of(chcfg_reg, i) && filtered_ext_trigger) begin
          etr_clear_reg[i] <= 1'b1; // [R17]
        end
        if (ms_of(chcfg_reg, i) == `TCC_MS_OUT) begin
          if (etr_clear_reg[i] || (etr_clr_of(chcfg_reg, i) && filtered_ext_trigger)) begin
            output_prepare_signal[i] <= 1'b0; // [R17]
          end else begin
            case (ctl_of(chcfg_reg, i))
              `TCC_CMP_FROZEN: ; // [R12]
              `TCC_CMP_SET: if (cmp_match[i]) output_prepare_signal[i] <= 1'b1;
              `TCC_CMP_CLEAR: if (cmp_match[i]) output_prepare_signal[i] <= 1'b0;
              `TCC_CMP_TOGGLE: if (cmp_match[i])
                output_prepare_signal[i] <= ~output_prepare_signal[i]; // [R12]
              `TCC_CMP_FLOW: output_prepare_signal[i] <= 1'b0; // [R13]
              `TCC_CMP_FHIGH: output_prepare_signal[i] <= 1'b1; // [R13]
              `TCC_CMP_PWM0: output_prepare_signal[i] <=
                count_reg < channel_value_reg[i]; // [R14] [R16]
              `TCC_CMP_PWM1: output_prepare_signal[i] <=
                ~(count_reg < channel_value_reg[i]); // [R14]
              default: ;
            endcase
          end
        end
      end
      // burst dma: count plus one requests per event
      if (burst_left_reg == 5'h0) begin
        if (any_dma_evt) begin
          burst_left_reg <= burst_transfer_count + 5'h1; // [R21]
          burst_idx_reg <= 5'h0;
          dma_request <= 1'b1;
        end
      end else if (psel && penable && buf_hit) begin
        burst_idx_reg <= burst_idx_reg + 5'h1; // [R21]
        burst_left_reg <= burst_left_reg - 5'h1;
        dma_request <= 1'b0;
      end else if (!dma_request && !psel) begin
        dma_request <= 1'b1;
      end
    end
  end
endmodule

//--- test/tcc_props.sv
/* tcc_props: port-level checks of tcc_channels.
   assumes the register map of tcc_map.vh and one clock. */
`timescale 1ns/10ps
module tcc_props (
  // clock and reset
  input wire clock,
  input wire resetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // outputs
  input wire [3:0] output_prepare_signal,
  input wire [3:0] channel_irq,
  input wire dma_request
);
  // ------------------------------------------------------------
  // snooped channel 0 config
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire wr = psel && penable && pwrite && pready;
  wire wr_irq = wr && (paddr == 8'h08 || paddr == 8'h0c);
  wire buf_acc = psel && paddr == 8'h34;
  reg [7:0] cfg0_reg;
  reg ien0_reg;
  wire out0 = cfg0_reg[1:0] == 2'h0 && !cfg0_reg[7];
  wire [2:0] ctl0 = cfg0_reg[6:4];
  always @(posedge clock) begin
    if (!resetn) begin
      cfg0_reg <= 8'h00;
      ien0_reg <= 1'b0;
    end else if (wr) begin
      if (paddr == 8'h14) cfg0_reg <= pwdata[7:0];
      if (paddr == 8'h08) ien0_reg <= pwdata[0];
    end
  end
  property p_ready_next; psel && !penable |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  property p_irq_sticky;
    |($past(channel_irq) & ~channel_irq) |-> $past(wr_irq) || $past(wr_irq, 2);
  endproperty
  property p_irq_enable; channel_irq[0] |-> ien0_reg || $past(ien0_reg); endproperty
  property p_force_low;
    out0 && ctl0 == 3'h4 && $past(ctl0) == 3'h4 |-> !output_prepare_signal[0];
  endproperty
  property p_force_high;
    out0 && ctl0 == 3'h5 && $past(ctl0) == 3'h5 |-> output_prepare_signal[0];
  endproperty
  property p_frozen;
    out0 && ctl0 == 3'h0 && $past(ctl0) == 3'h0 |=> $stable(output_prepare_signal[0]);
  endproperty
  property p_dma_hold;
    $fell(dma_request) |-> $past(buf_acc) || $past(buf_acc, 2);
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped alone");
  a_irq_enable: assert property (p_irq_enable) else $error("irq without enable");
  a_force_low: assert property (p_force_low) else $error("forced low not low");
  a_force_high: assert property (p_force_high) else $error("forced high not high");
  a_frozen: assert property (p_frozen) else $error("frozen output moved");
  a_dma_hold: assert property (p_dma_hold) else $error("dma request dropped alone");
  c_err: cover property (pslverr);
  c_dma: cover property ($fell(dma_request));
  c_irq: cover property (channel_irq[1]);
endmodule
bind tcc_channels tcc_props i_tcc_props (.clock, .resetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .output_prepare_signal, .channel_irq, .dma_request);

//--- test/tcc_pin_model.sv
/* tcc_pin_model: capture pin source for tcc_channels.
   assumes one-cycle requests from the bench; pins idle low. */
`timescale 1ns/10ps
module tcc_pin_model (
  // clock
  input wire clock,
  // pulse requests
  input wire [3:0] edge_req,
  // capture pins
  output reg [3:0] channel_input
);
  // ------------------------------------------------------------
  // pulse long enough to pass sync and filter
  // ------------------------------------------------------------
  reg [2:0] hold_cnt;
  initial begin
    channel_input = 4'h0;
    hold_cnt = 3'h0;
  end
  always @(posedge clock) begin
    if (|edge_req) begin
      channel_input <= edge_req;
      hold_cnt <= 3'h6;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end else begin
      channel_input <= 4'h0;
    end
  end
endmodule

//--- test/tcc_channels_bench.sv
/* tcc_channels_bench: apb-driven tests of tcc_channels.
   assumes a 25 MHz clock and the register map of tcc_map.vh. */
`timescale 1ns/10ps
module tcc_channels_bench;
  reg clock, resetn, psel, penable, pwrite, core_halted, filtered_ext_trigger;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd, v1;
  reg [3:0] internal_trigger_in, edge_req;
  reg er, last;
  wire [31:0] prdata;
  wire pready, pslverr, dma_request;
  wire [3:0] channel_input, output_prepare_signal, channel_irq;
  integer failures, n_compared, cycles, k, n, h;
  tcc_channels i_tcc_channels (.clock, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .channel_input, .internal_trigger_in,
    .filtered_ext_trigger, .core_halted, .dma_ack(1'b0), .output_prepare_signal,
    .channel_irq, .dma_request);
  tcc_pin_model i_tcc_pin_model (.clock, .edge_req, .channel_input);
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer t;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    t = 0;
    @(posedge clock);
    while (pready !== 1'b1 && t < 20) begin
      t = t + 1;
      @(posedge clock);
    end
    if (t == 20) failures = failures + 1;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clock);
  endtask
  // pin pulse, settle, then read the flags
  task pulse(input [3:0] p);
    edge_req <= p;
    tick(1);
    edge_req <= 4'h0;
    tick(20);
    apb(1'b0, 8'h0c, 32'h0);
  endtask
  // toggles into n, high cycles into h
  task span(input integer len);
    n = 0;
    h = 0;
    last = output_prepare_signal[0];
    repeat (len) begin
      @(posedge clock);
      if (output_prepare_signal[0] !== last) n = n + 1;
      if (output_prepare_signal[0] === 1'b1) h = h + 1;
      last = output_prepare_signal[0];
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      final_report;
    end
  end
  initial begin
    failures = 0;
    n_compared = 0;
    cycles = 0;
    {resetn, psel, penable, pwrite, core_halted, filtered_ext_trigger} = 6'h0;
    {paddr, pwdata, internal_trigger_in, edge_req} = 48'h0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rdc(8'h1c, 32'h0000ffff);
    apb(1'b0, 8'h3c, 32'h0);
    check({31'h0, er}, 32'h1);
    wr(8'h1c, 32'h9);
    wr(8'h20, 32'h3);
    wr(8'h08, 32'h1);
    wr(8'h14, 32'h18);
    wr(8'h00, 32'h1);
    tick(25);
    check({31'h0, output_prepare_signal[0]}, 32'h1);
    check({28'h0, channel_irq}, 32'h1);
    for (k = 2; k < 6; k = k + 1) begin
      wr(8'h14, {25'h0, k[2:0], 4'h8});
      tick(25);
      span(40);
      if (k == 3) check(n, 4);
      else check(h, k == 5 ? 40 : 0);
    end
    wr(8'h20, 32'ha);
    wr(8'h14, 32'h68);
    tick(12);
    span(20);
    check(h, 20);
    wr(8'h14, 32'he8);
    filtered_ext_trigger <= 1'b1;
    tick(3);
    check({31'h0, output_prepare_signal[0]}, 32'h0);
    filtered_ext_trigger <= 1'b0;
    wr(8'h20, 32'h0);
    wr(8'h14, 32'h68);
    tick(12);
    span(20);
    check(h, 0);
    wr(8'h14, 32'h00090000);
    wr(8'h0c, 32'h1ff);
    edge_req <= 4'h4;
    tick(1);
    edge_req <= 4'h0;
    tick(20);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd & 32'h44, 32'h4);
    apb(1'b0, 8'h28, 32'h0);
    v1 = rd;
    wr(8'h28, 32'h1234);
    rdc(8'h28, v1);
    edge_req <= 4'h4;
    tick(1);
    edge_req <= 4'h0;
    tick(20);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd & 32'h44, 32'h44);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd & 32'h44, 32'h44);
    wr(8'h14, 32'h8a090009);
    wr(8'h0c, 32'h1ff);
    pulse(4'h2);
    check(rd & 32'hd, 32'h1);
    pulse(4'h4);
    check(rd & 32'hc, 32'hc);
    wr(8'h14, 32'h00090000);
    wr(8'h00, 32'h0);
    wr(8'h0c, 32'h1ff);
    wr(8'h08, 32'h2);
    tick(2);
    check({31'h0, channel_irq[1]}, 32'h0);
    wr(8'h10, 32'h2);
    tick(3);
    check({31'h0, channel_irq[1]}, 32'h1);
    wr(8'h30, 32'h108);
    wr(8'h08, 32'h40);
    wr(8'h10, 32'h4);
    tick(3);
    check({31'h0, dma_request}, 32'h1);
    wr(8'h34, 32'h55);
    tick(3);
    check({31'h0, dma_request}, 32'h1);
    wr(8'h34, 32'h66);
    tick(3);
    check({31'h0, dma_request}, 32'h0);
    rdc(8'h20, 32'h55);
    rdc(8'h24, 32'h66);
    wr(8'h00, 32'h101);
    core_halted <= 1'b1;
    tick(2);
    apb(1'b0, 8'h18, 32'h0);
    v1 = rd;
    tick(5);
    rdc(8'h18, v1);
    core_halted <= 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h16);
    wr(8'h0c, 32'h1ff);
    internal_trigger_in <= 4'h2;
    tick(3);
    internal_trigger_in <= 4'h0;
    tick(2);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd & 32'h100, 32'h100);
    rdc(8'h00, 32'h1);
    wr(8'h04, 32'h05);
    wr(8'h00, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    v1 = rd;
    tick(5);
    rdc(8'h18, v1);
    final_report;
  end
endmodule
